// File: src/microstep_position_generator.sv
`timescale 1ns/1ps
// Overview of operation
// - Position moves only on rising step edge
// - Step size equals selected microstep increment
// - Direction captured at rising step edge
// - New direction applied before the step
// - Direction toggles alone change nothing
// - New resolution takes effect at next edge
// - Overshooting step lands on full step
// - Afterwards steps use selected increment
// - Up to 256 microsteps per full step
// - Nine-bit sine and cosine words out
// - Sine and cosine presented together
// - Two lookup tables give distinct pairs
// - Output disable does not block stepping
// - Reduce both currents after half-second idle
// - Reset disables outputs, restarts initial position
// - Outputs enabled while enable input high
// - Full-step flag high whole full-step time
// - Reset and enable act independent of step
module microstep_position_generator #(
    parameter int IDLE_CYCLES = stepgen_pkg::IDLE_CYCLES
) (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Motion controller pins
    input  wire logic                   step_in,
    input  wire logic                   dir_in,
    input  wire logic [3:0]             resolution_select,
    input  wire logic                   out_enable_in,
    // Phase DAC side
    output stepgen_pkg::sincos_type     sincos,
    output logic                        phase_enable,
    output logic                        full_step,
    output logic                        current_reduced
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic int quarter_sine(input int u);
        int p;
        p = u * (512 - u);
        return (255 * 16 * p) / (5 * 262144 - 4 * p);
    endfunction : quarter_sine

    function automatic logic [8:0] res_inc(input logic [3:0] code);
        logic [3:0] c;
        c = (code > stepgen_pkg::RES_MAX_CODE) ? stepgen_pkg::RES_MAX_CODE : code;
        return 9'h100 >> c;
    endfunction : res_inc

    function automatic logic [7:0] scale(input logic [7:0] m, input logic [7:0] s,
                                         input logic red);
        logic [15:0] prod;
        prod = m * s;
        return red ? prod[15:8] : m;
    endfunction : scale

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] pin_s1_q;
    logic [6:0] pin_s2_q;
    logic       step_prev_q;
    logic       step_rise;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_q <= 7'h00;
            pin_s2_q <= 7'h00;
            step_prev_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= {out_enable_in, resolution_select, dir_in, step_in};
            pin_s2_q <= pin_s1_q;
            step_prev_q <= pin_s2_q[0];
        end
    end

    assign step_rise = pin_s2_q[0] & ~step_prev_q;

    // ------------------------------------------------------------
    // Latched direction and resolution
    // ------------------------------------------------------------
    logic       dir_q;
    logic [3:0] res_q;
    logic       dir_now;
    logic [3:0] res_now;

    // Fresh values at the edge win over the old latched ones
    assign dir_now = step_rise ? pin_s2_q[1] : dir_q;
    assign res_now = step_rise ? pin_s2_q[5:2] : res_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_q <= 1'b0;
            res_q <= 4'h0;
        end
        else if (step_rise)
        begin
            dir_q <= dir_now;
            res_q <= res_now;
        end
    end

    // ------------------------------------------------------------
    // Position generator
    // ------------------------------------------------------------
    logic [9:0] pos_q;
    logic [8:0] inc;
    logic [9:0] fwd_sum;
    logic [1:0] quad;
    logic [7:0] ofs;
    logic [9:0] pos_d;
    logic [31:0] step_count_q;

    assign inc     = res_inc(res_now);
    assign quad    = pos_q[9:8];
    assign ofs     = pos_q[7:0];
    assign fwd_sum = {2'b00, ofs} + {1'b0, inc};

    always_comb
    begin
        pos_d = pos_q;
        if (dir_now)
        begin
            if (fwd_sum > 10'(stepgen_pkg::QUARTER))
                pos_d = {2'(quad + 2'd1), 8'h00};
            else
                pos_d = pos_q + {1'b0, inc};
        end
        else
        begin
            if (ofs != 8'h00 && {1'b0, ofs} < inc)
                pos_d = {quad, 8'h00};
            else
                pos_d = pos_q - {1'b0, inc};
        end
    end

    // Stepping continues while outputs are disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pos_q <= stepgen_pkg::POS_RESET;
        else if (step_rise)
            pos_q <= pos_d;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            step_count_q <= 32'h0000_0000;
        else if (step_rise)
            step_count_q <= step_count_q + 32'h0000_0001;
    end

    // ------------------------------------------------------------
    // Sine and cosine tables
    // ------------------------------------------------------------
    logic [7:0] sin_rom [0:255];
    logic [7:0] cos_rom [0:255];

    for (genvar i = 0; i < 256; i++)
    begin : g_rom
        assign sin_rom[i] = 8'(quarter_sine(i));
        assign cos_rom[i] = 8'(quarter_sine(256 - i));
    end

    stepgen_pkg::sincos_type lut;

    // Odd quadrants swap tables, signs follow the quadrant
    always_comb
    begin
        lut.sine.neg   = quad[1];
        lut.cosine.neg = quad[0] ^ quad[1];
        lut.sine.mag   = quad[0] ? cos_rom[ofs] : sin_rom[ofs];
        lut.cosine.mag = quad[0] ? sin_rom[ofs] : cos_rom[ofs];
    end

    // ------------------------------------------------------------
    // Idle current reduction
    // ------------------------------------------------------------
    logic [26:0] idle_cnt_q;
    logic        reduce_en_q;
    logic [7:0]  scale_q;
    logic        idle_done;

    assign idle_done = (idle_cnt_q >= 27'(IDLE_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_cnt_q <= 27'h0;
        else if (step_rise)
            idle_cnt_q <= 27'h0;
        else if (!idle_done)
            idle_cnt_q <= idle_cnt_q + 27'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            current_reduced <= 1'b0;
        else if (step_rise)
            current_reduced <= 1'b0;
        else
            current_reduced <= idle_done & reduce_en_q;
    end

    // ------------------------------------------------------------
    // Phase outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sincos <= stepgen_pkg::SINCOS_RESET;
        else
        begin
            sincos.sine.neg    <= lut.sine.neg;
            sincos.cosine.neg  <= lut.cosine.neg;
            sincos.sine.mag    <= scale(lut.sine.mag, scale_q, current_reduced);
            sincos.cosine.mag  <= scale(lut.cosine.mag, scale_q, current_reduced);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_enable <= 1'b0;
            full_step    <= 1'b1;
        end
        else
        begin
            phase_enable <= pin_s2_q[6];
            full_step    <= (ofs == 8'h00);
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic        access;
    logic        done;
    logic        mapped;
    logic [31:0] rd_val;

    assign access = psel & penable;
    assign done   = access & pready;
    assign mapped = (paddr == stepgen_pkg::CTRL_OFS) | (paddr == stepgen_pkg::STATUS_OFS)
                  | (paddr == stepgen_pkg::SINCOS_OFS)
                  | (paddr == stepgen_pkg::STEP_COUNT_OFS);

    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (paddr)
            stepgen_pkg::CTRL_OFS:
            begin
                rd_val[stepgen_pkg::CTRL_EN_BIT] = reduce_en_q;
                rd_val[stepgen_pkg::CTRL_SCALE_LSB +: 8] = scale_q;
            end
            stepgen_pkg::STATUS_OFS:
            begin
                rd_val[9:0] = pos_q;
                rd_val[stepgen_pkg::ST_FULL_BIT] = full_step;
                rd_val[stepgen_pkg::ST_RED_BIT] = current_reduced;
                rd_val[stepgen_pkg::ST_DIR_BIT] = dir_q;
                rd_val[stepgen_pkg::ST_RES_LSB +: 4] = res_q;
            end
            stepgen_pkg::SINCOS_OFS:
            begin
                rd_val[8:0] = sincos.sine;
                rd_val[stepgen_pkg::SC_COS_LSB +: 9] = sincos.cosine;
            end
            stepgen_pkg::STEP_COUNT_OFS:
                rd_val = step_count_q;
            default:
                rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (access && !pready)
        begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rd_val;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reduce_en_q <= stepgen_pkg::CTRL_EN_RESET;
            scale_q     <= stepgen_pkg::SCALE_RESET;
        end
        else if (done && pwrite && paddr == stepgen_pkg::CTRL_OFS)
        begin
            if (pstrb[0])
                reduce_en_q <= pwdata[stepgen_pkg::CTRL_EN_BIT];
            if (pstrb[1])
                scale_q <= pwdata[stepgen_pkg::CTRL_SCALE_LSB +: 8];
        end
    end

endmodule : microstep_position_generator

// File: inc/stepgen_pkg.sv
package stepgen_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ  = 200_000_000;
    localparam int IDLE_TIME_MS = 500;
    localparam int IDLE_CYCLES  = (CLK_FREQ_HZ / 1000) * IDLE_TIME_MS;
    localparam int IDLE_CNT_W   = 27;

    // ------------------------------------------------------------
    // Position and resolution
    // ------------------------------------------------------------
    localparam int          POS_W        = 10;
    localparam int          MAG_W        = 8;
    localparam int          RES_SEL_W    = 4;
    localparam int          QUARTER      = 256;
    localparam logic [3:0]  RES_MAX_CODE = 4'h8;
    localparam logic [9:0]  POS_RESET    = 10'h000;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS       = 8'h00;
    localparam logic [7:0]  STATUS_OFS     = 8'h04;
    localparam logic [7:0]  SINCOS_OFS     = 8'h08;
    localparam logic [7:0]  STEP_COUNT_OFS = 8'h0C;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_SCALE_LSB = 8;
    localparam logic        CTRL_EN_RESET  = 1'b1;
    localparam logic [7:0]  SCALE_RESET    = 8'h80;
    localparam int          ST_FULL_BIT    = 12;
    localparam int          ST_RED_BIT     = 13;
    localparam int          ST_DIR_BIT     = 14;
    localparam int          ST_RES_LSB     = 16;
    localparam int          SC_COS_LSB     = 16;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       neg;
        logic [7:0] mag;
    } phase_word_type;

    typedef struct packed {
        phase_word_type sine;
        phase_word_type cosine;
    } sincos_type;

    localparam sincos_type SINCOS_RESET = '{
        sine:   '{neg: 1'b0, mag: 8'h00},
        cosine: '{neg: 1'b0, mag: 8'hFF}
    };

endpackage : stepgen_pkg

// File: sim/microstep_position_generator_props.sv
`timescale 1ns/1ps
module microstep_position_generator_props #(
    parameter int IDLE_CYCLES = 200
) (
    // Clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // Pins
    input wire logic                    step_in,
    input wire logic                    out_enable_in,
    // Outputs
    input wire stepgen_pkg::sincos_type sincos,
    input wire logic                    phase_enable,
    input wire logic                    full_step,
    input wire logic                    current_reduced
);
    // ------------------------------------------------------------
    // Step history and idle count
    // ------------------------------------------------------------
    logic [6:0] hist_q;
    int         idle_q;
    logic       recent;

    assign recent = |(hist_q[5:1] & ~hist_q[6:2]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hist_q <= 7'h00;
            idle_q <= 0;
        end
        else
        begin
            hist_q <= {hist_q[5:0], step_in};
            idle_q <= (hist_q[0] && !hist_q[1]) ? 0 : idle_q + int'(idle_q < IDLE_CYCLES + 64);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_moves_on_step: assert property ($changed(sincos) && !current_reduced
        |-> recent)
        else $error("Phase words moved without a step");
    a_full_zero: assert property (full_step
        |-> sincos.sine.mag == 8'h00 || sincos.cosine.mag == 8'h00)
        else $error("Full step flag off a zero crossing");
    a_full_with_pair: assert property ($changed(full_step) |-> $changed(sincos))
        else $error("Full step flag moved apart from phase words");
    a_reset_init: assert property ($rose(presetn) |-> !phase_enable && full_step
        && !current_reduced && sincos == stepgen_pkg::SINCOS_RESET)
        else $error("Wrong state after reset");
    a_enable_on: assert property (out_enable_in [*8] |-> phase_enable)
        else $error("Outputs not enabled");
    a_enable_off: assert property (!out_enable_in [*4] |-> !phase_enable)
        else $error("Outputs not disabled");
    a_reduce_idle: assert property (idle_q > IDLE_CYCLES + 6 |-> current_reduced)
        else $error("No reduction after idle");
    a_restore_step: assert property (idle_q > 4 && idle_q < IDLE_CYCLES - 4
        |-> !current_reduced)
        else $error("Reduction while stepping");

    cover property (current_reduced ##1 !current_reduced);
    cover property ($rose(full_step));
    cover property (!phase_enable && recent);
endmodule : microstep_position_generator_props

bind microstep_position_generator microstep_position_generator_props #(
    .IDLE_CYCLES(IDLE_CYCLES)
) u_microstep_position_generator_props (
    .pclk, .presetn, .step_in, .out_enable_in, .sincos, .phase_enable, .full_step, .current_reduced
);

// File: sim/step_controller_model.sv
`timescale 1ns/1ps
module step_controller_model (
    // Motion controller pins
    output logic       step_in,
    output logic       dir_in,
    output logic [3:0] resolution_select
);
    // ------------------------------------------------------------
    // Link clock, running only during a move
    // ------------------------------------------------------------
    logic lclk = 1'b0;
    logic run  = 1'b0;

    initial
    begin
        step_in = 1'b0;
        dir_in = 1'b1;
        resolution_select = 4'h8;
    end

    always #32 lclk = run ? ~lclk : 1'b0;

    task automatic move(input logic d, input logic [3:0] r, input int n);
        run = 1'b1;
        @(posedge lclk);
        dir_in <= d;
        resolution_select <= r;
        repeat (n)
        begin
            @(posedge lclk);
            step_in <= 1'b1;
            @(posedge lclk);
            step_in <= 1'b0;
        end
        @(posedge lclk);
        run = 1'b0;
    endtask : move

    task automatic jog(input logic d, input logic [3:0] r);
        dir_in <= d;
        resolution_select <= r;
    endtask : jog
endmodule : step_controller_model

// File: sim/microstep_position_generator_tb.sv
`timescale 1ns/1ps
module microstep_position_generator_tb;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    localparam int IDLE = 200;
    logic                    pclk = 1'b0;
    logic                    presetn = 1'b0;
    logic                    psel = 1'b0;
    logic                    penable = 1'b0;
    logic                    pwrite = 1'b0;
    logic [7:0]              paddr = 8'h00;
    logic [31:0]             pwdata = 32'h0000_0000;
    logic [3:0]              pstrb = 4'h0;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    step_in;
    logic                    dir_in;
    logic [3:0]              resolution_select;
    logic                    out_enable_in = 1'b1;
    stepgen_pkg::sincos_type sincos;
    logic                    phase_enable;
    logic                    full_step;
    logic                    current_reduced;
    logic [31:0]             rd;
    logic                    er;
    int                      errors = 0;
    int                      comparisons = 0;
    int                      pos = 0;

    always #2.5 pclk = ~pclk;

    microstep_position_generator #(.IDLE_CYCLES(IDLE)) u_microstep_position_generator (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .step_in, .dir_in, .resolution_select, .out_enable_in, .sincos,
        .phase_enable, .full_step, .current_reduced
    );

    step_controller_model u_step_controller_model (.step_in, .dir_in, .resolution_select);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic go(input logic d, input logic [3:0] r, input int n);
        int inc;
        int off;
        inc = 256 >> ((r > 4'h8) ? 4'h8 : r);
        u_step_controller_model.move(d, r, n);
        repeat (n)
        begin
            off = pos % 256;
            if (d)
                pos = (off + inc > 256) ? pos - off + 256 : pos + inc;
            else
                pos = (off != 0 && off < inc) ? pos - off : pos - inc;
            pos = (pos + 1024) % 1024;
        end
        apb(1'b0, 8'h04, 32'h0000_0000, 4'h0, rd, er);
        chk(rd & 32'h0000_03FF, pos);
        chk(32'(rd[14]), 32'(d));
        chk(32'(rd[19:16]), 32'(r));
        chk(32'(full_step), 32'(pos % 256 == 0));
        chk(32'(current_reduced), 0);
        if (pos % 256 == 0)
            chk(32'({sincos.sine.mag, sincos.cosine.mag}),
                (pos % 512 != 0) ? 32'h0000_FF00 : 32'h0000_00FF);
    endtask : go

    task automatic t_codes;
        for (int c = 0; c < 16; c++)
            go(1'b1, 4'(c), 1);
    endtask : t_codes

    task automatic t_align;
        go(1'b1, 4'h1, 2);
        go(1'b1, 4'h1, 1);
        go(1'b0, 4'h8, 1);
        go(1'b0, 4'h0, 2);
    endtask : t_align

    task automatic t_hold;
        logic [17:0] s0;
        s0 = sincos;
        repeat (4)
        begin
            u_step_controller_model.jog(~dir_in, 4'h3);
            repeat (20) @(posedge pclk);
            chk(32'(sincos), 32'(s0));
        end
        go(dir_in, 4'h8, 1);
    endtask : t_hold

    task automatic t_disable;
        out_enable_in <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(32'(phase_enable), 0);
        go(1'b1, 4'h2, 3);
        out_enable_in <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(phase_enable), 1);
    endtask : t_disable

    task automatic t_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        chk(32'(phase_enable), 0);
        chk(32'(sincos), 32'(stepgen_pkg::SINCOS_RESET));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        pos = 0;
        repeat (10) @(posedge pclk);
        go(1'b1, 4'h8, 1);
        apb(1'b0, 8'h0C, 32'h0000_0000, 4'h0, rd, er);
        chk(rd, 32'h0000_0001);
    endtask : t_reset

    task automatic t_idle;
        apb(1'b1, 8'h00, 32'h0000_4000, 4'h2, rd, er);
        apb(1'b0, 8'h00, 32'h0000_0000, 4'h0, rd, er);
        chk(rd, 32'h0000_4001);
        apb(1'b0, 8'h10, 32'h0000_0000, 4'h0, rd, er);
        chk({rd[30:0], er}, 32'h0000_0001);
        go(1'b1, 4'h0, 1);
        repeat (IDLE + 20) @(posedge pclk);
        chk(32'(current_reduced), 1);
        chk(32'({sincos.sine.mag, sincos.cosine.mag}),
            (pos % 512 != 0) ? 32'h0000_3F00 : 32'h0000_003F);
        go(1'b1, 4'h0, 1);
    endtask : t_idle

    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_codes;
        t_align;
        t_hold;
        t_disable;
        t_reset;
        t_idle;
        final_report;
    end

    initial
    begin
        #200000;
        errors++;
        final_report;
    end
endmodule : microstep_position_generator_tb
